// ---- hdl/ousf_pkg.sv ----
package ousf_pkg;

    localparam logic [7:0] START_DELIM = 8'h7E;
    localparam logic [7:0] FRAME_TYPE = 8'hA0;
    localparam logic [15:0] FRAME_DATA_LEN = 16'h0016;
    localparam logic [4:0] LAST_OFFSET = 5'h19;
    localparam logic [4:0] OFS_TYPE = 5'h03;
    localparam logic [4:0] OFS_SRC = 5'h04;
    localparam logic [4:0] OFS_SHORT = 5'h0C;
    localparam logic [4:0] OFS_OPTS = 5'h0E;
    localparam logic [4:0] OFS_MSG = 5'h0F;
    localparam logic [4:0] OFS_BLOCK = 5'h10;
    localparam logic [4:0] OFS_TARGET = 5'h11;
    localparam logic [7:0] OPT_ACKED = 8'h01;
    localparam logic [7:0] OPT_BCAST = 8'h02;
    localparam logic [7:0] MSG_ACK = 8'h06;
    localparam logic [7:0] MSG_NACK = 8'h15;
    localparam logic [7:0] MSG_NO_MAC_ACK = 8'h40;
    localparam logic [7:0] MSG_QUERY = 8'h51;
    localparam logic [7:0] MSG_QUERY_RESP = 8'h52;
    localparam logic [7:0] QUERY_CMD_HI = 8'h01;
    localparam logic [7:0] QUERY_CMD_LO = 8'h51;
    localparam int CLK_HZ = 20000000;
    localparam int TARGET_TIMEOUT_S = 75;
    localparam int FIFO_DEPTH = 16;

    typedef struct packed {
        logic [63:0] srcAddr;
        logic [15:0] updaterShort;
        logic broadcast;
        logic [7:0] msgType;
        logic blockValid;
        logic [7:0] blockNum;
        logic [63:0] targetAddr;
    } ousf_report_type;

endpackage : ousf_pkg

// ---- hdl/ousf_fifo.sv ----
module ousf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic [AW-1:0] next_wrPtr;
    logic [AW-1:0] next_rdPtr;
    logic [AW:0] next_count;
    logic doWr;
    logic doRd;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        inReady = (count != (AW+1)'(DEPTH));
        outValid = (count != '0);
        outData = mem[rdPtr];
        doWr = inValid && inReady;
        doRd = outValid && outReady;
        next_wrPtr = doWr ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr = doRd ? rdPtr + 1'b1 : rdPtr;
        next_count = count + (AW+1)'(doWr) - (AW+1)'(doRd);
    end

    // storage has no reset: only entries written since rdPtr last passed them are taken, while count is nonzero
    always_ff @(posedge core_clk)
    begin
        if (clkEn && doWr)
        begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else if (clkEn)
        begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    a_fifo_no_overflow: assert property (@(posedge core_clk) disable iff (!reset_n)
        count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule : ousf_fifo

// ---- hdl/ousf_framer.sv ----
// How it works
// - every update status report goes out as a frame whose type byte is A0.
// - bytes 4 to 11 carry the responding radio's 64-bit address, most significant first.
// - bytes 12 and 13 carry the updater's 16-bit short address, high byte first.
// - byte 14 is 01 for an acknowledged packet and 02 for a broadcast.
// - byte 15 is the bootloader message type: 06, 15, 40, 51 or 52.
// - byte 16 is the block number, or zero when no block number applies.
// - bytes from 17 carry the 64-bit target address, most significant first.
// - a NACK means the target awaits an image; after about 75 s quiet it takes queries again.
module ousf_framer #(
    parameter int FIFO_DEPTH = ousf_pkg::FIFO_DEPTH,
    parameter int TIMEOUT_CYCLES = ousf_pkg::TARGET_TIMEOUT_S * ousf_pkg::CLK_HZ
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic reportValid,
    output logic reportReady,
    input wire ousf_pkg::ousf_report_type report,
    output logic txValid,
    input wire logic txReady,
    output logic [7:0] txData,
    output logic nackWaiting,
    output logic bootInactive
);
    typedef enum logic [1:0] {IDLE, SEND} ousf_state_type;

    ousf_state_type state;
    ousf_state_type next_state;
    ousf_pkg::ousf_report_type held;
    ousf_pkg::ousf_report_type next_held;
    logic [4:0] offset;
    logic [4:0] next_offset;
    logic [7:0] sum;
    logic [7:0] next_sum;
    logic [7:0] byteOut;
    logic fifoReady;
    logic pushByte;
    logic [31:0] quietCount;
    logic [31:0] next_quietCount;
    logic next_nackWaiting;
    logic next_bootInactive;
    logic [2:0] idx;

    ////////////////////////////////////////////////////////////////////////////
    // byte selection by frame offset
    always_comb
    begin
        byteOut = '0;
        idx = '0;
        if (offset == 5'h00)
            byteOut = ousf_pkg::START_DELIM;
        else if (offset == 5'h01)
            byteOut = ousf_pkg::FRAME_DATA_LEN[15:8];
        else if (offset == 5'h02)
            byteOut = ousf_pkg::FRAME_DATA_LEN[7:0];
        else if (offset == ousf_pkg::OFS_TYPE)
            byteOut = ousf_pkg::FRAME_TYPE;
        else if (offset < ousf_pkg::OFS_SHORT)
        begin
            idx = 3'(offset - ousf_pkg::OFS_SRC);
            byteOut = held.srcAddr[8*(7-idx) +: 8];
        end
        else if (offset == ousf_pkg::OFS_SHORT)
            byteOut = held.updaterShort[15:8];
        else if (offset == 5'h0D)
            byteOut = held.updaterShort[7:0];
        else if (offset == ousf_pkg::OFS_OPTS)
            byteOut = held.broadcast ? ousf_pkg::OPT_BCAST : ousf_pkg::OPT_ACKED;
        else if (offset == ousf_pkg::OFS_MSG)
            byteOut = held.msgType;
        else if (offset == ousf_pkg::OFS_BLOCK)
            byteOut = held.blockValid ? held.blockNum : 8'h00;
        else if (offset < ousf_pkg::LAST_OFFSET)
        begin
            idx = 3'(offset - ousf_pkg::OFS_TARGET);
            byteOut = held.targetAddr[8*(7-idx) +: 8];
        end
        else
            byteOut = 8'hFF - sum;
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame sequencer; back-pressure from the fifo stalls the walk
    always_comb
    begin
        next_state = state;
        next_held = held;
        next_offset = offset;
        next_sum = sum;
        reportReady = (state == IDLE);
        pushByte = (state == SEND);
        unique case (state)
            IDLE:
            begin
                if (reportValid)
                begin
                    next_held = report;
                    next_offset = '0;
                    next_sum = '0;
                    next_state = SEND;
                end
            end
            SEND:
            begin
                if (fifoReady)
                begin
                    if (offset >= ousf_pkg::OFS_TYPE)
                        next_sum = sum + byteOut;
                    if (offset == ousf_pkg::LAST_OFFSET)
                        next_state = IDLE;
                    else
                        next_offset = offset + 5'h01;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= IDLE;
            held <= '0;
            offset <= '0;
            sum <= '0;
        end
        else if (clkEn)
        begin
            state <= next_state;
            held <= next_held;
            offset <= next_offset;
            sum <= next_sum;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // target condition seen from reports; the timeout only clears a stale flag
    always_comb
    begin
        next_nackWaiting = nackWaiting;
        next_bootInactive = bootInactive;
        next_quietCount = quietCount;
        if (nackWaiting)
        begin
            if (quietCount >= 32'(TIMEOUT_CYCLES - 1))
                next_nackWaiting = 1'b0;
            else
                next_quietCount = quietCount + 32'h00000001;
        end
        if (reportValid && reportReady)
        begin
            next_quietCount = '0;
            next_nackWaiting = (report.msgType == ousf_pkg::MSG_NACK);
            next_bootInactive = (report.msgType == ousf_pkg::MSG_QUERY);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            nackWaiting <= 1'b0;
            bootInactive <= 1'b0;
            quietCount <= '0;
        end
        else if (clkEn)
        begin
            nackWaiting <= next_nackWaiting;
            bootInactive <= next_bootInactive;
            quietCount <= next_quietCount;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    ousf_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .inValid(pushByte),
        .inReady(fifoReady),
        .inData(byteOut),
        .outValid(txValid),
        .outReady(txReady),
        .outData(txData)
    );

    a_type_byte: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state == SEND && offset == ousf_pkg::OFS_TYPE) |-> byteOut == 8'hA0)
        else $error("type byte wrong");
    a_src_msb: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state == SEND && offset == 5'h04) |-> byteOut == held.srcAddr[63:56])
        else $error("source msb wrong");
    a_short_lsb: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state == SEND && offset == 5'h0D) |-> byteOut == held.updaterShort[7:0])
        else $error("short address lsb wrong");
    a_opts_byte: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state == SEND && offset == 5'h0E) |-> byteOut == (held.broadcast ? 8'h02 : 8'h01))
        else $error("options byte wrong");
    a_msg_byte: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state == SEND && offset == 5'h0F) |-> byteOut == held.msgType)
        else $error("message type wrong");
    a_block_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state == SEND && offset == 5'h10 && !held.blockValid) |-> byteOut == 8'h00)
        else $error("block not zero");
    a_target_lsb: assert property (@(posedge core_clk) disable iff (!reset_n)
        (state == SEND && offset == 5'h18) |-> byteOut == held.targetAddr[7:0])
        else $error("target lsb wrong");
    a_frame_start: assert property (@(posedge core_clk) disable iff (!reset_n)
        (clkEn && state == IDLE && reportValid) |=> (state == SEND && offset == 5'h00
        && byteOut == 8'h7E))
        else $error("frame start wrong");
    a_inactive_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
        (clkEn && reportValid && reportReady && report.msgType == 8'h51) |=> bootInactive)
        else $error("inactive flag not set");

endmodule : ousf_framer

// ---- test/ousf_host_model.sv ----
module ousf_host_model (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic slow,
    input wire logic txValid,
    input wire logic [7:0] txData,
    output logic txReady,
    output logic [7:0] got [0:255],
    output int gotCount
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;
    ////////////////////////////////////////////////////////////////////////////////
    // slow mode takes one byte in four, so the framer backs up behind a full buffer
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phase <= 2'h0;
            txReady <= 1'b0;
            gotCount <= 0;
        end
        else
        begin
            phase <= phase + 2'h1;
            txReady <= !slow || (phase == 2'h2);
            if (clear)
                gotCount <= 0;
            else if (txValid === 1'b1 && txReady)
            begin
                got[gotCount[7:0]] <= txData;
                gotCount <= gotCount + 1;
            end
        end
    end
endmodule : ousf_host_model

// ---- test/tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, reset_n, clkEn, reportValid, reportReady, txValid, txReady;
    logic nackWaiting, bootInactive, clear, slow;
    logic [7:0] txData;
    logic [7:0] got [0:255];
    int gotCount, n_fail, total_checks, cycles;
    ousf_pkg::ousf_report_type report, r;
    logic [7:0] codes [5] = '{8'h06, 8'h15, 8'h40, 8'h51, 8'h52};

    ousf_framer #(.TIMEOUT_CYCLES(200)) ousf_framer_i (.core_clk(core_clk), .reset_n(reset_n),
        .clkEn(clkEn), .reportValid(reportValid), .reportReady(reportReady), .report(report),
        .txValid(txValid), .txReady(txReady), .txData(txData), .nackWaiting(nackWaiting),
        .bootInactive(bootInactive));
    ousf_host_model ousf_host_model_i (.core_clk(core_clk), .reset_n(reset_n), .clear(clear),
        .slow(slow), .txValid(txValid), .txData(txData), .txReady(txReady), .got(got),
        .gotCount(gotCount));
    ////////////////////////////////////////////////////////////////////////////////
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // report is held until taken; valid stays up so back-to-back reports need no gap
    task send(input ousf_pkg::ousf_report_type v);
        int n;
        n = 0;
        report = v;
        reportValid = 1'b1;
        while (reportReady !== 1'b1 && n < 200)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("report ready", {7'h00, reportReady}, 8'h01);
        @(posedge core_clk);
        #1;
        check("report taken", {7'h00, reportReady}, 8'h00);
    endtask : send

    task wait_bytes(input int cnt);
        int n;
        n = 0;
        reportValid = 1'b0;
        while (gotCount < cnt && n < 2000)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("byte count", 8'(gotCount), 8'(cnt));
    endtask : wait_bytes

    // expected bytes worked out independently of the design
    task check_frame(input int base, input ousf_pkg::ousf_report_type v);
        logic [7:0] f [26];
        logic [7:0] sum;
        f[0] = 8'h7E;
        f[1] = 8'h00;
        f[2] = 8'h16;
        f[3] = 8'hA0;
        for (int i = 0; i < 8; i++)
        begin
            f[4 + i] = v.srcAddr[63 - 8 * i -: 8];
            f[17 + i] = v.targetAddr[63 - 8 * i -: 8];
        end
        f[12] = v.updaterShort[15:8];
        f[13] = v.updaterShort[7:0];
        f[14] = v.broadcast ? 8'h02 : 8'h01;
        f[15] = v.msgType;
        f[16] = v.blockValid ? v.blockNum : 8'h00;
        sum = 8'h00;
        for (int i = 3; i < 25; i++)
            sum = sum + f[i];
        f[25] = 8'hFF - sum;
        for (int i = 0; i < 12; i++)
            check($sformatf("frame byte %0d", i), got[base + i], f[i]);
        for (int i = 12; i < 17; i++)
            check($sformatf("frame byte %0d", i), got[base + i], f[i]);
        for (int i = 17; i < 26; i++)
            check($sformatf("frame byte %0d", i), got[base + i], f[i]);
    endtask : check_frame
    ////////////////////////////////////////////////////////////////////////////////
    task s_query_reply();
        r = '{64'h1122334455667788, 16'hABCD, 1'b0, 8'h52, 1'b0, 8'h5A, 64'h8877665544332211};
        send(r);
        wait_bytes(26);
        check_frame(0, r);
        check("boot inactive", {7'h00, bootInactive}, 8'h00);
    endtask : s_query_reply

    // every message type back to back while the host stalls and the buffer fills
    task s_types_stalled();
        ousf_pkg::ousf_report_type q [5];
        clear = 1'b1;
        slow = 1'b1;
        @(posedge core_clk);
        #1;
        clear = 1'b0;
        for (int k = 0; k < 5; k++)
        begin
            q[k] = '{64'hF0E1D2C3B4A59687 + k, 16'(16'h0100 * k), k[0], codes[k], k[1],
                8'(8'hFE + k), 64'h0123456789ABCDEF ^ k};
            send(q[k]);
        end
        wait_bytes(130);
        for (int k = 0; k < 5; k++)
            check_frame(26 * k, q[k]);
        slow = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        check("drained", {7'h00, txValid}, 8'h00);
    endtask : s_types_stalled

    task s_status_flags();
        clear = 1'b1;
        @(posedge core_clk);
        #1;
        clear = 1'b0;
        r = '{64'h0, 16'h0002, 1'b1, 8'h15, 1'b1, 8'h07, 64'h99};
        send(r);
        wait_bytes(26);
        check("nack waiting", {7'h00, nackWaiting}, 8'h01);
        // a frozen clock enable must also freeze the quiet-time count
        clkEn = 1'b0;
        repeat (220) @(posedge core_clk);
        #1;
        check("nack frozen", {7'h00, nackWaiting}, 8'h01);
        clkEn = 1'b1;
        repeat (220) @(posedge core_clk);
        #1;
        check("nack expired", {7'h00, nackWaiting}, 8'h00);
        r.msgType = 8'h51;
        send(r);
        wait_bytes(52);
        check("boot inactive", {7'h00, bootInactive}, 8'h01);
        check("nack after query", {7'h00, nackWaiting}, 8'h00);
    endtask : s_status_flags
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // a hang counts as a mismatch and ends the run
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_fail++;
            wrap_up();
        end
    end

    initial
    begin
        n_fail = 0;
        total_checks = 0;
        cycles = 0;
        reset_n = 1'b0;
        clkEn = 1'b1;
        reportValid = 1'b0;
        report = '0;
        clear = 1'b0;
        slow = 1'b0;
        repeat (8) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        s_query_reply();
        s_types_stalled();
        s_status_flags();
        wrap_up();
    end
endmodule : tb
